// >>> hdl/pui_pkg.sv
// Package: register map, field positions, reset values and types
package pui_pkg;

  // Register byte offsets
  localparam logic [7:0] OPT_OFS    = 8'h00; // option switches, rw
  localparam logic [7:0] STAT_OFS   = 8'h04; // status, read; w1c parity error, change and cleared bits
  localparam logic [7:0] DATA_OFS   = 8'h08; // user data latch, read pops
  localparam logic [7:0] PANEL_OFS  = 8'h0C; // panel, interlocks, lines/page
  localparam logic [7:0] VFU_OFS    = 8'h10; // selected bottom-of-form channel, read only; writes ignored

  // Option field positions within OPT register
  localparam int OPT_NOT_INST   = 0;
  localparam int OPT_PI_DIS     = 1;
  localparam int OPT_D8_DIS     = 2;
  localparam int OPT_CLR_LOW    = 3;
  localparam int OPT_LOW_TRUE   = 4;
  localparam int OPT_PAR_D8     = 5;
  localparam int OPT_PAR_PI     = 6;
  localparam int OPT_PAR_EN     = 7;
  localparam int OPT_SKIPOVER   = 8;
  localparam int OPT_BOF_SEL_A  = 9;
  localparam int OPT_BOF_SEL_B  = 10;
  localparam int OPT_TAPE_UNIT  = 12;
  localparam int OPT_PM_ALT     = 13;
  localparam int OPT_TOF_CH9    = 14;
  localparam int OPT_PM_CH9     = 15;

  // Status field positions
  localparam int ST_FULL     = 0;
  localparam int ST_PAR_ERR  = 1;
  localparam int ST_CHANGE   = 2;
  localparam int ST_SKIP     = 3;
  localparam int ST_TAPE_RD  = 4;
  localparam int ST_CLEARED  = 5;

  localparam logic [15:0] OPT_RESET = 16'h0000;
  localparam logic [3:0]  VFU_RESET = 4'h0;

  // Debounce: 1 ms interlock settling time at 125 MHz
  localparam int MCLK_MHZ     = 125;
  localparam int DEB_US       = 1000;
  localparam int DEB_CYCLES   = DEB_US * MCLK_MHZ;
  localparam int DEB_W        = 17;
  localparam int N_ILK        = 4;

  // Tape channel numbers for bottom of form selection
  localparam logic [3:0] BOF_CH_00 = 4'd12;
  localparam logic [3:0] BOF_CH_01 = 4'd11;
  localparam logic [3:0] BOF_CH_10 = 4'd2;
  localparam logic [3:0] BOF_CH_11 = 4'd8;

  // Forms length selector code to lines per page
  localparam logic [7:0] LPP_TAB [16] = '{
    8'd66, 8'd72, 8'd84, 8'd88, 8'd11, 8'd12, 8'd14, 8'd17,
    8'd22, 8'd24, 8'd28, 8'd33, 8'd42, 8'd44, 8'd51, 8'd60};

  typedef struct packed {
    logic       strobe;
    logic [7:0] data;
    logic       paper_instruction_line;
    logic       parity;
    logic       buffer_clear;
  } pui_host_in_t;

  typedef struct packed {
    logic paper_moving_status;
    logic top_of_form;
    logic verify;
    logic verify_oe_n;
    logic no_format_unit;
  } pui_host_out_t;

  typedef struct packed {
    logic [15:0]          opt;
    logic [3:0]           vertical_format_unit;
    logic [7:0]           data;
    logic                 pi;
    logic                 full;
    logic                 par_err;
    logic                 change;
    logic                 skip;
    logic                 tape_rd;
    logic                 cleared;
    logic                 strobe_q;
    logic                 alarm_q;
    logic [N_ILK-1:0]     ilk;
    logic [N_ILK-1:0]     ilk_raw;
    logic [DEB_W-1:0]     deb_cnt;
    logic [7:0]           lpp;
    pui_host_out_t        hout;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 started;
  } pui_state_t;

endpackage : pui_pkg

// >>> hdl/pui_top.sv
// Printer user interface configuration front end with APB registers
// Overview of operation
// RL1: Option settings are readable by the processor in a register.
// RL2: One received character held in a latch until the processor reads it.
// RL3: Interlock inputs are debounced before the processor sees them.
// RL4: Panel state readable; alarm/clear activation sets a change flag.
// RL5: Forms length selector is translated to lines per page.
// RL6: Not-installed option reports no format unit and drives verify path.
// RL7: Paper-instruction disable blocks the line from the control latch.
// RL8: Eighth-bit disable gates data bit 8 before the data latch.
// RL9: Buffer-clear polarity option selects low or high active clear.
// RL10: Interface polarity option selects low-true or high-true signalling.
// RL11: Parity-data option makes data bit 8 the eighth parity input.
// RL12: Parity-instruction option makes paper instruction the eighth input.
// RL13: Parity enable option turns received data parity checking on or off.
// RL14: Skipover extends a stop between bottom and top of form to top.
// RL15: Two options select bottom-of-form channel 12, 11, 2 or 8.
// RL16: Tape unit option requests a tape read after reset; options reset to zero, so only newly setting the option requests one.
// RL17: Paper-moving source option picks real motion or alternate report.
// RL18: Alternate report carries channel 9 or format-unit ready.
// RL19: Top-of-form line reports channel 9 or channel 1.
// RL20: Polarity is one inversion at receivers and drivers.
// RL21: Options are sampled on the clock and act from reset onward.
module pui_top (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire pui_pkg::pui_host_in_t host_in,
  output pui_pkg::pui_host_out_t     host_out,
  input  wire logic                  paper_motion,
  input  wire logic [12:1]           tape_channel,
  input  wire logic                  fu_ready,
  input  wire logic [pui_pkg::N_ILK-1:0] interlock_in,
  input  wire logic                  alarm_clear_sw,
  input  wire logic [3:0]            forms_length_selector,
  output logic                       bottom_of_form,
  output logic                       skip_active,
  output logic                       tape_read_req
);

  pui_pkg::pui_state_t s_q;
  pui_pkg::pui_state_t s_d;

  logic                 inv;
  pui_pkg::pui_host_in_t hi;
  logic                 clr_in;
  logic [7:0]           dat;
  logic                 par8;
  logic                 par_bad;
  logic [3:0]           bof_ch;
  logic                 bof_hit;
  logic                 tof_hit;
  logic                 acc;
  logic                 wr;
  logic                 rd;

  always_comb begin
    inv     = s_q.opt[pui_pkg::OPT_LOW_TRUE];
    hi      = host_in ^ {$bits(host_in){inv}};                   // [RL10] [RL20]
    clr_in  = s_q.opt[pui_pkg::OPT_CLR_LOW] ? ~host_in.buffer_clear
                                            : host_in.buffer_clear; // [RL9]
    dat     = hi.data;
    if (s_q.opt[pui_pkg::OPT_D8_DIS]) begin
      dat[7] = 1'b0;                                             // [RL8]
    end
    par8 = 1'b0;                                                 // [RL12]
    if (s_q.opt[pui_pkg::OPT_PAR_D8]) begin
      par8 = dat[7];                                             // [RL11]
    end else if (s_q.opt[pui_pkg::OPT_PAR_PI]) begin
      par8 = hi.paper_instruction_line &
             ~s_q.opt[pui_pkg::OPT_PI_DIS];                      // [RL12]
    end
    // Odd parity across seven data bits, eighth input and parity line
    par_bad = s_q.opt[pui_pkg::OPT_PAR_EN] &
              ~(^{dat[6:0], par8, hi.parity});                   // [RL13]
    unique case ({s_q.opt[pui_pkg::OPT_BOF_SEL_A],
                  s_q.opt[pui_pkg::OPT_BOF_SEL_B]})
      2'b00: bof_ch = pui_pkg::BOF_CH_00;                        // [RL15]
      2'b01: bof_ch = pui_pkg::BOF_CH_01;
      2'b10: bof_ch = pui_pkg::BOF_CH_10;
      2'b11: bof_ch = pui_pkg::BOF_CH_11;
    endcase
    bof_hit = tape_channel[bof_ch];
    tof_hit = tape_channel[1];
    acc = psel & penable;
    wr  = acc & pwrite;
    rd  = acc & ~pwrite;
  end

  always_comb begin
    s_d = s_q;
    s_d.strobe_q = hi.strobe;
    s_d.alarm_q  = alarm_clear_sw;
    s_d.pready   = acc & ~s_q.pready;
    s_d.pslverr  = 1'b0;
    s_d.prdata   = 32'h0000_0000;
    // Data latch: one character at a time, extra strobes while full dropped
    if (hi.strobe && !s_q.strobe_q && !s_q.full) begin
      s_d.data = dat;                                            // [RL2]
      s_d.pi   = hi.paper_instruction_line &
                 ~s_q.opt[pui_pkg::OPT_PI_DIS];                  // [RL7]
      s_d.full = 1'b1;
      s_d.par_err = s_q.par_err | par_bad;                       // [RL13]
    end
    if (clr_in) begin
      s_d.full    = 1'b0;                                        // [RL9]
      s_d.cleared = 1'b1;
    end
    // Interlock debounce: state accepted after a stable settling interval
    s_d.ilk_raw = interlock_in;
    if (interlock_in != s_q.ilk_raw) begin
      s_d.deb_cnt = '0;
    end else if (s_q.deb_cnt ==
                 pui_pkg::DEB_W'(pui_pkg::DEB_CYCLES - 1)) begin
      s_d.ilk = s_q.ilk_raw;                                     // [RL3]
    end else begin
      s_d.deb_cnt = s_q.deb_cnt + 1'b1;
    end
    s_d.lpp = pui_pkg::LPP_TAB[forms_length_selector];           // [RL5]
    // Skipover: stopping in the bottom-to-top gap keeps paper moving
    if (s_q.skip) begin
      if (tof_hit) begin
        s_d.skip = 1'b0;
      end
    end else if (s_q.opt[pui_pkg::OPT_SKIPOVER] && bof_hit &&
                 !paper_motion) begin
      s_d.skip = 1'b1;                                           // [RL14]
    end
    if (!s_q.started) begin
      s_d.started = 1'b1;
      s_d.tape_rd = s_q.opt[pui_pkg::OPT_TAPE_UNIT];             // [RL16]
    end else if (fu_ready) begin
      s_d.tape_rd = 1'b0;
    end
    // Host drivers; paper moving, top of form and no format unit inverted once when low-true is selected
    s_d.hout.paper_moving_status = inv ^
      (s_q.opt[pui_pkg::OPT_PM_ALT]
        ? (s_q.opt[pui_pkg::OPT_PM_CH9] ? tape_channel[9] : fu_ready)
        : paper_motion);                                         // [RL17] [RL18]
    s_d.hout.top_of_form = inv ^
      (s_q.opt[pui_pkg::OPT_TOF_CH9] ? tape_channel[9]
                                     : tape_channel[1]);         // [RL19]
    s_d.hout.no_format_unit = inv ^ s_q.opt[pui_pkg::OPT_NOT_INST]; // [RL6]
    s_d.hout.verify      = 1'b0;
    s_d.hout.verify_oe_n = ~s_q.opt[pui_pkg::OPT_NOT_INST];     // [RL6]
    // APB access; one wait state, answer at second access edge
    if (rd && !s_q.pready) begin
      unique case (paddr)
        pui_pkg::OPT_OFS:   s_d.prdata = {16'h0000, s_q.opt};    // [RL1]
        pui_pkg::STAT_OFS:  s_d.prdata = {26'h000_0000, s_q.cleared,
                              s_q.tape_rd, s_q.skip, s_q.change,
                              s_q.par_err, s_q.full};
        pui_pkg::DATA_OFS:  s_d.prdata = {23'h00_0000, s_q.pi, s_q.data};
        pui_pkg::PANEL_OFS: s_d.prdata = {16'h0000, s_q.lpp, 2'b00,
                              alarm_clear_sw, 1'b0, s_q.ilk};    // [RL4]
        pui_pkg::VFU_OFS:   s_d.prdata = {28'h000_0000, bof_ch};
        default:            s_d.pslverr = 1'b1;
      endcase
    end
    // Write error flagged with the answer; write lands at the answer edge
    if (wr && !s_q.pready) begin
      unique case (paddr)
        pui_pkg::OPT_OFS, pui_pkg::STAT_OFS, pui_pkg::DATA_OFS,
        pui_pkg::PANEL_OFS, pui_pkg::VFU_OFS: ;
        default: s_d.pslverr = 1'b1;
      endcase
    end
    if (wr && s_q.pready) begin
      unique case (paddr)
        pui_pkg::OPT_OFS: begin
          s_d.opt = pwdata[15:0];                                // [RL21]
          // A newly selected tape unit asks for a tape read
          if (pwdata[pui_pkg::OPT_TAPE_UNIT] &&
              !s_q.opt[pui_pkg::OPT_TAPE_UNIT]) begin
            s_d.tape_rd = 1'b1;                                  // [RL16]
          end
        end
        pui_pkg::STAT_OFS: begin
          if (pwdata[pui_pkg::ST_PAR_ERR]) s_d.par_err = 1'b0;
          if (pwdata[pui_pkg::ST_CHANGE])  s_d.change  = 1'b0;
          if (pwdata[pui_pkg::ST_CLEARED]) s_d.cleared = 1'b0;
        end
        default: ;
      endcase
    end
    if (rd && s_q.pready && paddr == pui_pkg::DATA_OFS) begin
      s_d.full = 1'b0;                                           // [RL2]
    end
    // Set wins over a simultaneous clear
    if (alarm_clear_sw && !s_q.alarm_q) begin
      s_d.change = 1'b1;                                         // [RL4]
    end
    if (hi.strobe && !s_q.strobe_q && !s_q.full && par_bad) begin
      s_d.par_err = 1'b1;                                        // [RL13]
    end
    if (clr_in) begin
      s_d.cleared = 1'b1;                                        // [RL9]
    end
    if (rst) begin
      s_d = '0;
      s_d.opt = pui_pkg::OPT_RESET;
      s_d.vertical_format_unit = pui_pkg::VFU_RESET;
      s_d.hout.verify_oe_n = 1'b1;
    end
  end

  logic bof_q;

  always_ff @(posedge mclk) begin
    s_q <= s_d;
  end

  assign prdata         = s_q.prdata;
  assign pready         = s_q.pready;
  assign pslverr        = s_q.pslverr;
  assign host_out       = s_q.hout;
  assign skip_active    = s_q.skip;
  assign tape_read_req  = s_q.tape_rd;
  assign bottom_of_form = bof_q;

  always_ff @(posedge mclk) begin
    bof_q <= rst ? 1'b0 : bof_hit;                               // [RL15]
  end

  // Assertions
  alarm_flag_a: assert property (@(posedge mclk) disable iff (rst) // [RL4]
    alarm_clear_sw && !s_q.alarm_q |=> s_q.change)
    else $error("alarm change flag not set");
  latch_hold_a: assert property (@(posedge mclk) disable iff (rst) // [RL2]
    s_q.full && !clr_in && !(rd && s_q.pready) |=> $stable(s_q.data))
    else $error("held character overwritten");
  verify_path_a: assert property (@(posedge mclk) disable iff (rst) // [RL6]
    !s_q.opt[pui_pkg::OPT_NOT_INST] |=> host_out.verify_oe_n)
    else $error("verify path driven while option off");
  bit8_gate_a: assert property (@(posedge mclk) disable iff (rst) // [RL8]
    s_q.opt[pui_pkg::OPT_D8_DIS] && !s_q.full && hi.strobe
      && !s_q.strobe_q |=> !s_q.data[7])
    else $error("bit 8 latched in 7-bit mode");
  pi_block_a: assert property (@(posedge mclk) disable iff (rst) // [RL7]
    s_q.opt[pui_pkg::OPT_PI_DIS] && $changed(s_q.data) |-> !s_q.pi)
    else $error("paper instruction passed while disabled");
  par_off_a: assert property (@(posedge mclk) disable iff (rst) // [RL13]
    !s_q.opt[pui_pkg::OPT_PAR_EN] && !s_q.par_err |=> !s_q.par_err)
    else $error("parity error with check disabled");
  tof_src_a: assert property (@(posedge mclk) disable iff (rst) // [RL19]
    1'b1 |=> host_out.top_of_form == ($past(inv) ^
      ($past(s_q.opt[pui_pkg::OPT_TOF_CH9]) ? $past(tape_channel[9])
                                             : $past(tape_channel[1]))))
    else $error("top of form source wrong");
  skip_end_a: assert property (@(posedge mclk) disable iff (rst) // [RL14]
    s_q.skip && tof_hit |=> !s_q.skip)
    else $error("skipover ran past top of form");
  sequence apb_wait_s;
    psel && penable && !pready;
  endsequence
  sequence apb_done_s;
    pready ##1 !pready;
  endsequence
  apb_answer_a: assert property (@(posedge mclk) disable iff (rst)
    apb_wait_s |=> apb_done_s)
    else $error("apb answer late or held");
  skip_set_a: assert property (@(posedge mclk) disable iff (rst) // [RL14]
    !s_q.skip && s_q.opt[pui_pkg::OPT_SKIPOVER] && bof_hit && !paper_motion
      |=> skip_active)
    else $error("skipover not started");
  tape_req_a: assert property (@(posedge mclk) disable iff (rst) // [RL16]
    wr && s_q.pready && paddr == pui_pkg::OPT_OFS
      && pwdata[pui_pkg::OPT_TAPE_UNIT] && !s_q.opt[pui_pkg::OPT_TAPE_UNIT]
      |=> tape_read_req)
    else $error("tape read not requested");

endmodule : pui_top

// >>> testbench/pui_host_model.sv
// Host system model driving the parallel printer cable
module pui_host_model (
  output pui_pkg::pui_host_in_t host_in,
  input  wire logic             mclk,
  input  wire logic             low_true,
  input  wire logic             clr_low
);
  timeunit 1ns;
  timeprecision 1ps;
  pui_pkg::pui_host_in_t lv = '0;

  // Levels kept true-sense; the cable sees them inverted when low-true, buffer clear only when clear-low
  always_comb begin
    host_in = low_true ? ~lv : lv;
    host_in.buffer_clear = lv.buffer_clear ^ clr_low;
  end

  task automatic send(input logic [7:0] d, input logic pi, input logic par);
    @(posedge mclk);
    {lv.data, lv.paper_instruction_line, lv.parity} <= {d, pi, par};
    @(posedge mclk);
    lv.strobe <= 1'b1;
    repeat (4) @(posedge mclk);
    lv.strobe <= 1'b0;
    repeat (2) @(posedge mclk);
    // Released lines do not keep the last character
    {lv.data, lv.paper_instruction_line, lv.parity} <= ~{d, pi, par};
  endtask : send

  task automatic clear();
    @(posedge mclk);
    lv.buffer_clear <= 1'b1;
    repeat (4) @(posedge mclk);
    lv.buffer_clear <= 1'b0;
  endtask : clear
endmodule : pui_host_model

// >>> testbench/tb_printer_user_interface_config.sv
// Self-checking bench for the printer user interface front end
module tb_printer_user_interface_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   mclk = 1'b0;
  logic                   rst = 1'b1;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [7:0]             paddr = '0;
  logic [31:0]            pwdata = '0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  pui_pkg::pui_host_in_t  host_in;
  pui_pkg::pui_host_out_t host_out;
  logic                   paper_motion = 1'b0;
  logic [12:1]            tape_channel = '0;
  logic                   fu_ready = 1'b0;
  logic [3:0]             interlock_in = '0;
  logic                   alarm_clear_sw = 1'b0;
  logic [3:0]             fls = '0;
  logic                   bottom_of_form;
  logic                   skp;
  logic                   trq;
  logic [15:0]            opt = '0;
  logic [31:0]            rd;
  logic                   er;
  int                     error_cnt = 0;
  int                     total_checks = 0;
  int                     seed = 76;

  always #4 mclk = ~mclk;

  pui_top dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_in(host_in),
    .host_out(host_out), .paper_motion(paper_motion),
    .tape_channel(tape_channel), .fu_ready(fu_ready),
    .interlock_in(interlock_in), .alarm_clear_sw(alarm_clear_sw),
    .forms_length_selector(fls), .bottom_of_form(bottom_of_form),
    .skip_active(skp), .tape_read_req(trq));

  pui_host_model host (.host_in(host_in), .mclk(mclk),
    .low_true(opt[pui_pkg::OPT_LOW_TRUE]),
    .clr_low(opt[pui_pkg::OPT_CLR_LOW]));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (n >= 40) error_cnt++;
  endtask : apb

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(nm, e, rd & m);
  endtask : rdchk

  // Options change, then any stray character and the sticky parity error, change and cleared flags are dropped
  task automatic setopt(input logic [15:0] o);
    apb(1'b1, pui_pkg::OPT_OFS, {16'h0000, o});
    opt <= o;
    repeat (4) @(posedge mclk);
    apb(1'b0, pui_pkg::DATA_OFS, '0);
    apb(1'b1, pui_pkg::STAT_OFS, 32'h0000_0026);
  endtask : setopt

  function automatic logic [31:0] exp_data(input logic [7:0] d,
                                           input logic pi);
    logic [7:0] x;
    logic       p;
    x = opt[pui_pkg::OPT_D8_DIS] ? {1'b0, d[6:0]} : d;
    p = opt[pui_pkg::OPT_PI_DIS] ? 1'b0 : pi;
    return {23'h00_0000, p, x};
  endfunction : exp_data

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    logic [31:0] v;
    logic [15:0] o;
    logic        e8;
    int          bofc[4];
    bofc = '{12, 11, 2, 8};
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rdchk("opt reset", pui_pkg::OPT_OFS, '1, '0);
    chk("out reset", 32'h0000_0002, {27'h0, host_out});
    for (int i = 0; i < 4; i++) begin
      v = $random(seed) & 32'h0000_F7FF;
      apb(1'b1, pui_pkg::OPT_OFS, v);
      rdchk("opt", pui_pkg::OPT_OFS, '1, v);
    end
    apb(1'b0, 8'h14, '0);
    chk("unmapped", 32'h0000_0001, {31'h0, er});
    for (int i = 0; i < 4; i++) begin
      o = '0;
      o[pui_pkg::OPT_D8_DIS] = i[0];
      o[pui_pkg::OPT_PI_DIS] = i[1];
      o[pui_pkg::OPT_LOW_TRUE] = (i == 3);
      setopt(o);
      v = $random(seed);
      host.send(v[7:0], v[8], 1'b0);
      host.send(~v[7:0], ~v[8], 1'b0);
      rdchk("full", pui_pkg::STAT_OFS, 32'h0000_0001, 32'h0000_0001);
      rdchk("data", pui_pkg::DATA_OFS, 32'h0000_01FF, exp_data(v[7:0], v[8]));
      rdchk("empty", pui_pkg::STAT_OFS, 32'h0000_0001, '0);
    end
    for (int k = 0; k < 4; k++) begin
      o = '0;
      o[pui_pkg::OPT_PAR_EN] = (k != 2);
      o[pui_pkg::OPT_PAR_D8] = (k < 3);
      o[pui_pkg::OPT_PAR_PI] = (k == 3);
      setopt(o);
      v = $random(seed);
      e8 = (k == 3) ? 1'b1 : v[7];
      host.send(v[7:0], k == 3, ~^{v[6:0], e8} ^ (k == 1 || k == 2));
      rdchk("parity", pui_pkg::STAT_OFS, 32'h0000_0002, {30'h0, k == 1, 1'b0});
    end
    for (int j = 0; j < 2; j++) begin
      setopt({15'h0000, j[0]});
      chk("no unit", {30'h0, j[0], ~j[0]}, {30'h0, host_out.no_format_unit, host_out.verify_oe_n});
    end
    for (int j = 0; j < 4; j++) begin
      setopt({5'h00, j[0], j[1], 9'h000});
      tape_channel <= 12'h001 << (bofc[j] - 1);
      repeat (3) @(posedge mclk);
      chk("bof on", 32'h0000_0001, {31'h0, bottom_of_form});
      tape_channel <= ~(12'h001 << (bofc[j] - 1));
      repeat (3) @(posedge mclk);
      chk("bof off", '0, {31'h0, bottom_of_form});
    end
    {tape_channel, paper_motion, fu_ready} <= {12'h100, 2'b10};
    for (int m = 0; m < 4; m++) begin
      setopt({m[0], m[0], m[1], 13'h0000});
      chk("tof", {31'h0, m[0]}, {31'h0, host_out.top_of_form});
      chk("moving", {31'h0, m[1] ? m[0] : 1'b1}, {31'h0, host_out.paper_moving_status});
    end
    for (int c = 0; c < 2; c++) begin
      setopt({12'h000, c[0], 3'h0});
      v = $random(seed);
      host.send(v[7:0], 1'b0, 1'b0);
      host.clear();
      rdchk("clear", pui_pkg::STAT_OFS, 32'h0000_0021, 32'h0000_0020);
    end
    alarm_clear_sw <= 1'b1;
    repeat (4) @(posedge mclk);
    rdchk("change", pui_pkg::STAT_OFS, 32'h0000_0004, 32'h0000_0004);
    rdchk("alarm", pui_pkg::PANEL_OFS, 32'h0000_0020, 32'h0000_0020);
    apb(1'b1, pui_pkg::STAT_OFS, 32'h0000_0004);
    rdchk("change clr", pui_pkg::STAT_OFS, 32'h0000_0004, '0);
    v = $random(seed);
    {fls, interlock_in} <= {v[3:0], 4'hF};
    repeat (10) @(posedge mclk);
    interlock_in <= 4'h0;
    rdchk("panel", pui_pkg::PANEL_OFS, 32'h0000_FF0F, {16'h0, pui_pkg::LPP_TAB[v[3:0]], 8'h00});
    setopt(16'h1000);
    chk("tape req", 32'h0000_0001, {31'h0, trq});
    rdchk("tape stat", pui_pkg::STAT_OFS, 32'h0000_0010, 32'h0000_0010);
    fu_ready <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("tape done", '0, {31'h0, trq});
    setopt(16'h0100);
    {tape_channel, paper_motion} <= {12'h800, 1'b0};
    repeat (3) @(posedge mclk);
    chk("skip on", 32'h0000_0001, {31'h0, skp});
    tape_channel <= 12'h001;
    repeat (3) @(posedge mclk);
    chk("skip off", '0, {31'h0, skp});
    report_and_stop();
  end
endmodule : tb_printer_user_interface_config
